// [usb_dbg_pkg.sv]
// constants, register layout and states of the usb debug port controller
// assumes a 25 MHz core clock and a 32-bit apb register bus
`default_nettype none
package usb_dbg_pkg;
  // clock and times
  localparam int unsigned CLK_MHZ          = 25;
  localparam int unsigned POLL_US          = 125;
  localparam int unsigned SLOT_CYC         = POLL_US * CLK_MHZ;           // longest poll gap, exact product
  localparam int unsigned KA_US            = 1000;                        // keepalive spacing, under 2 ms
  localparam int unsigned KA_CYC           = KA_US * CLK_MHZ;
  localparam int unsigned RESP_NS          = 1600;                        // handshake wait
  localparam int unsigned RESP_CYC         = (RESP_NS * CLK_MHZ) / 1000;
  // fixed debug root port
  localparam int unsigned NUM_PORTS        = 4;
  localparam int unsigned DBG_PORT         = 1;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL         = 8'h00;
  localparam logic [7:0]  OFS_PIDS         = 8'h04;
  localparam logic [7:0]  OFS_DATA0        = 8'h08;
  localparam logic [7:0]  OFS_DATA1        = 8'h0c;
  localparam logic [7:0]  OFS_ADDR         = 8'h10;
  localparam logic [7:0]  OFS_STAT         = 8'h14;
  // control register fields
  localparam int unsigned CTRL_LEN_LSB     = 0;
  localparam int unsigned CTRL_DIR         = 4;
  localparam int unsigned CTRL_GO          = 5;
  localparam int unsigned CTRL_EXC_LSB     = 7;
  localparam int unsigned CTRL_ERR         = 6;
  localparam int unsigned CTRL_IN_USE      = 10;
  localparam int unsigned CTRL_DONE        = 16;
  localparam int unsigned CTRL_ENABLE      = 28;
  localparam int unsigned CTRL_OWNER       = 30;
  // address register fields
  localparam int unsigned ADDR_EP_LSB      = 0;
  localparam int unsigned ADDR_DEV_LSB     = 8;
  // pid register fields
  localparam int unsigned PID_TOK_LSB      = 0;
  localparam int unsigned PID_SEND_LSB     = 8;
  localparam int unsigned PID_RET_LSB      = 16;
  // values
  localparam logic [2:0]  EXC_NONE         = 3'h0;
  localparam logic [2:0]  EXC_NO_RESP      = 3'h1;
  localparam logic [2:0]  EXC_ABORT        = 3'h2;
  localparam logic [3:0]  MAX_LEN          = 4'h8;
  localparam logic [4:0]  CRC5_INIT        = 5'h1f;
  localparam logic [4:0]  CRC5_POLY        = 5'h14;
  localparam logic [15:0] CRC16_INIT       = 16'hffff;
  localparam logic [15:0] CRC16_POLY       = 16'ha001;
  // transaction states
  typedef enum logic [2:0] {ST_IDLE, ST_TOKEN, ST_DATA, ST_WAIT} dbg_state_t;
endpackage : usb_dbg_pkg
`default_nettype wire

// [usb_debug_port_controller.sv]
// usb debug port controller: apb registers, mode select, token/data/handshake sequencing
// assumes port status comes from host controller logic on core_clk and a byte phy behind tx/rx
//
// Functional notes
// [R1] debug works only on root port one of the host controller
// [R2] debug logic keeps working while the standard driver sees the port disabled
// [R3] console is high-speed and attached directly, never through a hub
// [R4] every transaction completes; a bad outcome is reported, never stalls
// [R5] at most one bus access per microframe for debug transactions
// [R6] debug runs only while port not suspended and controller fully on
// [R7] debug is interrupted while the port drives a bus reset
// [R8] with run/stop at 0, keepalives go out less than 2 ms apart
// [R9] a keepalive is a lone 32-bit sync, nothing after it
// [R10] with run/stop at 1, sof keeps the console awake, no keepalive
// [R11] pending software transactions are polled at least every 125 us
// [R12] port reset holds debug off until the first sof after it
// [R13] suspend and resume hold debug off until the first sof after them
// [R14] debug enable and port enable are separate bits, neither changes the other
// [R15] owner or enable low leaves the debug logic idle
// [R16] owner, enable set, port off, stopped: sync keepalives and debug traffic
// [R17] owner, enable set, port off, running: sof only, no normal traffic
// [R18] port on and running: debug interleaves with normal traffic
// [R19] port suspended with debug on: no debug traffic at all
// [R20] driver never leaves port enabled, stopped and unsuspended
// [R21] out transfer starts only if enabled, direction write and go set
// [R22] software programs address, endpoint, data, pids, length, direction, then go
// [R23] token is sync, token pid, address, endpoint and crc5
// [R24] out data packet is sync, send pid, length bytes and crc16
// [R25] handshake received: store pid, clear error, set done
// [R26] no handshake: exception 001, set error, set done
`default_nettype none
module usb_debug_port_controller #(
  parameter int unsigned KA_CYCLES = usb_dbg_pkg::KA_CYC      // keepalive spacing in cycles
) (
  input  wire logic        core_clk,                        // core clock
  input  wire logic        nrst,                            // async reset, active low
  input  wire logic        psel,                            // apb select
  input  wire logic        penable,                         // apb access phase
  input  wire logic        pwrite,                          // apb direction
  input  wire logic [7:0]  paddr,                           // apb byte address
  input  wire logic [31:0] pwdata,                          // apb write data
  output logic      [31:0] prdata,                          // apb read data
  output logic             pready,                          // apb ready
  output logic             pslverr,                         // apb error, unmapped address
  input  wire logic [3:0]  port_enable,                     // per root port enable bits
  input  wire logic [3:0]  port_suspend,                    // per root port suspended
  input  wire logic [3:0]  port_reset,                      // per root port driving reset
  input  wire logic        run_stop,                        // host controller running
  input  wire logic        power_d0,                        // controller fully on
  input  wire logic        sof_sent,                        // pulse: sof went out
  input  wire logic        tx_ready,                        // phy takes tx byte
  input  wire logic        rx_valid,                        // pulse: first received byte (pid)
  input  wire logic [7:0]  rx_data,                         // received byte
  output logic             tx_valid,                        // byte offered to phy
  output logic      [7:0]  tx_data,                         // byte to phy, sync added by phy
  output logic             tx_last,                         // last byte of packet
  output logic             keepalive_sync,                  // pulse: send a lone sync
  output logic             debug_active,                    // debug traffic allowed now
  output logic             normal_block                     // normal traffic barred on the port
);

  // reflected usb crc steps, lsb first
  function automatic logic [4:0] crc5_calc(input logic [10:0] d);
    logic [4:0] c;
    c = usb_dbg_pkg::CRC5_INIT;
    for (int i = 0; i < 11; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ usb_dbg_pkg::CRC5_POLY) : (c >> 1);
    end
    return ~c;
  endfunction : crc5_calc

  function automatic logic [15:0] crc16_byte(input logic [15:0] ci, input logic [7:0] d);
    logic [15:0] c;
    c = ci;
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ usb_dbg_pkg::CRC16_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc16_byte

  usb_dbg_pkg::dbg_state_t st_ff, nxt_st;
  logic        owner_ff, nxt_owner, enable_ff, nxt_enable, go_ff, nxt_go, dir_ff, nxt_dir;
  logic        done_ff, nxt_done, err_ff, nxt_err, hold_ff, nxt_hold, ka_ff, nxt_ka;
  logic [2:0]  exc_ff, nxt_exc;
  logic [3:0]  len_ff, nxt_len, ep_ff, nxt_ep, idx_ff, nxt_idx;
  logic [6:0]  dev_ff, nxt_dev;
  logic [7:0]  tpid_ff, nxt_tpid, spid_ff, nxt_spid, rpid_ff, nxt_rpid;
  logic [63:0] buf_ff, nxt_buf;
  logic [15:0] crc_ff, nxt_crc, slot_ff, nxt_slot;
  logic [31:0] ka_cnt_ff, nxt_ka_cnt, prdata_ff, nxt_prdata;
  logic [7:0]  wait_ff, nxt_wait, txd_ff, nxt_txd;
  logic        txv_ff, nxt_txv, txl_ff, nxt_txl, rdy_ff, nxt_rdy, serr_ff, nxt_serr;
  logic        act_ff, nxt_act, blk_ff, nxt_blk;
  logic        cfg_on, p_en, p_susp, p_rst, may_run, mode1, slot_hit, start, wr, rd, hit, beat;
  logic [4:0]  tok_crc;
  logic [7:0]  cur_byte;

  // port state of the fixed debug port only
  assign p_en     = port_enable[usb_dbg_pkg::DBG_PORT];   // see [R1]
  assign p_susp   = port_suspend[usb_dbg_pkg::DBG_PORT];  // see [R1]
  assign p_rst    = port_reset[usb_dbg_pkg::DBG_PORT];    // see [R1]
  // mode selection; port enable only decides interleaving, never gates debug
  assign cfg_on   = owner_ff & enable_ff;                             // see [R15] [R2]
  assign may_run  = cfg_on & power_d0 & !p_susp & !p_rst & !hold_ff;  // see [R6] [R7] [R19]
  assign mode1    = may_run & !run_stop;                              // see [R16] [R10]
  assign slot_hit = (slot_ff == 16'(usb_dbg_pkg::SLOT_CYC - 1));
  // go polled once per slot: one access per microframe
  assign start    = (st_ff == usb_dbg_pkg::ST_IDLE) & may_run & go_ff & slot_hit & !ka_ff; // see [R5] [R11] [R21]
  assign beat     = txv_ff & tx_ready;
  assign wr       = psel & penable & rdy_ff & pwrite;
  assign rd       = psel & !penable & !pwrite;
  assign hit      = (paddr <= usb_dbg_pkg::OFS_STAT) & (paddr[1:0] == 2'h0);
  assign tok_crc  = crc5_calc({ep_ff, dev_ff});                       // see [R23]
  assign cur_byte = buf_ff[{idx_ff[2:0] - 3'h1, 3'h0} +: 8];

  // registers, timers and transaction sequencing
  always_comb begin
    nxt_st = st_ff; nxt_owner = owner_ff; nxt_enable = enable_ff; nxt_go = go_ff;
    nxt_dir = dir_ff; nxt_done = done_ff; nxt_err = err_ff; nxt_exc = exc_ff;
    nxt_len = len_ff; nxt_ep = ep_ff; nxt_dev = dev_ff; nxt_tpid = tpid_ff;
    nxt_spid = spid_ff; nxt_rpid = rpid_ff; nxt_buf = buf_ff; nxt_crc = crc_ff;
    nxt_idx = idx_ff; nxt_wait = wait_ff; nxt_txd = txd_ff; nxt_txv = txv_ff; nxt_txl = txl_ff;
    nxt_ka = 1'b0;
    nxt_slot = slot_hit ? 16'h0000 : slot_ff + 16'h0001;
    nxt_ka_cnt = ka_cnt_ff;
    // hold off from reset or suspend until the next sof; with no sof running, until it ends
    nxt_hold = hold_ff;
    if (p_rst | p_susp) begin
      nxt_hold = cfg_on;                                        // see [R12] [R13]
    end else if (sof_sent | !run_stop) begin
      nxt_hold = 1'b0;                                          // see [R12] [R13]
    end
    // keepalive only when stopped; any packet restarts the spacing
    if (!mode1 | start | (st_ff != usb_dbg_pkg::ST_IDLE)) begin
      nxt_ka_cnt = 32'h0;                                       // see [R10]
    end else if (ka_cnt_ff == KA_CYCLES - 1) begin
      nxt_ka_cnt = 32'h0;
      nxt_ka = 1'b1;                                            // see [R8] [R9] [R16]
    end else begin
      nxt_ka_cnt = ka_cnt_ff + 32'h1;
    end
    // apb writes; enable is stored apart from the port enable input
    if (wr) begin
      if (paddr == usb_dbg_pkg::OFS_CTRL) begin
        nxt_owner  = pwdata[usb_dbg_pkg::CTRL_OWNER];
        nxt_enable = pwdata[usb_dbg_pkg::CTRL_ENABLE];         // see [R14]
        nxt_len    = pwdata[usb_dbg_pkg::CTRL_LEN_LSB +: 4];
        nxt_dir    = pwdata[usb_dbg_pkg::CTRL_DIR];
        nxt_go     = pwdata[usb_dbg_pkg::CTRL_GO] | go_ff;
        if (pwdata[usb_dbg_pkg::CTRL_DONE]) begin
          nxt_done = 1'b0;                                      // write one clears
        end
      end else if (paddr == usb_dbg_pkg::OFS_PIDS) begin
        nxt_tpid = pwdata[usb_dbg_pkg::PID_TOK_LSB +: 8];
        nxt_spid = pwdata[usb_dbg_pkg::PID_SEND_LSB +: 8];
      end else if (paddr == usb_dbg_pkg::OFS_DATA0) begin
        nxt_buf[31:0] = pwdata;
      end else if (paddr == usb_dbg_pkg::OFS_DATA1) begin
        nxt_buf[63:32] = pwdata;
      end else if (paddr == usb_dbg_pkg::OFS_ADDR) begin
        nxt_ep  = pwdata[usb_dbg_pkg::ADDR_EP_LSB +: 4];
        nxt_dev = pwdata[usb_dbg_pkg::ADDR_DEV_LSB +: 7];
      end
    end
    // transaction sequencing; status set below wins over the software clear above
    case (st_ff)
      usb_dbg_pkg::ST_IDLE: begin
        if (start) begin
          nxt_go  = 1'b0;
          nxt_st  = usb_dbg_pkg::ST_TOKEN;
          nxt_idx = 4'h0;
          nxt_txv = 1'b1;
          nxt_txl = 1'b0;
          nxt_txd = tpid_ff;                                    // see [R23]
          if (len_ff > usb_dbg_pkg::MAX_LEN) begin
            nxt_len = usb_dbg_pkg::MAX_LEN;
          end
        end
      end
      usb_dbg_pkg::ST_TOKEN: begin
        if (beat) begin
          nxt_idx = idx_ff + 4'h1;
          nxt_crc = usb_dbg_pkg::CRC16_INIT;
          if (idx_ff == 4'h0) begin
            nxt_txd = {ep_ff[0], dev_ff};                       // see [R23]
          end else if (idx_ff == 4'h1) begin
            nxt_txd = {tok_crc, ep_ff[3:1]};                    // see [R23]
            nxt_txl = 1'b1;
          end else if (dir_ff) begin
            nxt_st  = usb_dbg_pkg::ST_DATA;                     // see [R24]
            nxt_idx = 4'h0;
            nxt_txd = spid_ff;
            nxt_txl = 1'b0;
          end else begin
            nxt_st   = usb_dbg_pkg::ST_WAIT;
            nxt_txv  = 1'b0;
            nxt_wait = 8'h00;
          end
        end
      end
      usb_dbg_pkg::ST_DATA: begin
        if (beat) begin
          nxt_idx = idx_ff + 4'h1;
          if (idx_ff != 4'h0 && idx_ff <= len_ff) begin
            nxt_crc = crc16_byte(crc_ff, cur_byte);             // see [R24]
          end
          if (idx_ff < len_ff) begin
            nxt_txd = buf_ff[{idx_ff[2:0], 3'h0} +: 8];         // see [R24]
          end else if (idx_ff == len_ff) begin
            nxt_txd = ~nxt_crc[7:0];
          end else if (idx_ff == len_ff + 4'h1) begin
            nxt_txd = ~crc_ff[15:8];
            nxt_txl = 1'b1;
          end else begin
            nxt_st   = usb_dbg_pkg::ST_WAIT;
            nxt_txv  = 1'b0;
            nxt_txl  = 1'b0;
            nxt_wait = 8'h00;
          end
        end
      end
      usb_dbg_pkg::ST_WAIT: begin
        nxt_wait = wait_ff + 8'h01;
        if (rx_valid) begin
          nxt_rpid = rx_data;                                   // see [R25]
          nxt_err  = 1'b0;
          nxt_exc  = usb_dbg_pkg::EXC_NONE;
          nxt_done = 1'b1;
          nxt_st   = usb_dbg_pkg::ST_IDLE;
        end else if (p_rst | (wait_ff == 8'(usb_dbg_pkg::RESP_CYC - 1))) begin
          nxt_exc  = p_rst ? usb_dbg_pkg::EXC_ABORT : usb_dbg_pkg::EXC_NO_RESP; // see [R26] [R7]
          nxt_err  = 1'b1;                                      // see [R4]
          nxt_done = 1'b1;
          nxt_st   = usb_dbg_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st = usb_dbg_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff <= usb_dbg_pkg::ST_IDLE; owner_ff <= 1'b0; enable_ff <= 1'b0; go_ff <= 1'b0;
      dir_ff <= 1'b0; done_ff <= 1'b0; err_ff <= 1'b0; exc_ff <= usb_dbg_pkg::EXC_NONE;
      len_ff <= 4'h0; ep_ff <= 4'h0; dev_ff <= 7'h00; tpid_ff <= 8'h00; spid_ff <= 8'h00;
      rpid_ff <= 8'h00; buf_ff <= 64'h0; crc_ff <= usb_dbg_pkg::CRC16_INIT; idx_ff <= 4'h0;
      wait_ff <= 8'h00; txd_ff <= 8'h00; txv_ff <= 1'b0; txl_ff <= 1'b0; hold_ff <= 1'b0;
      ka_ff <= 1'b0; slot_ff <= 16'h0000; ka_cnt_ff <= 32'h0;
    end else begin
      st_ff <= nxt_st; owner_ff <= nxt_owner; enable_ff <= nxt_enable; go_ff <= nxt_go;
      dir_ff <= nxt_dir; done_ff <= nxt_done; err_ff <= nxt_err; exc_ff <= nxt_exc;
      len_ff <= nxt_len; ep_ff <= nxt_ep; dev_ff <= nxt_dev; tpid_ff <= nxt_tpid; spid_ff <= nxt_spid;
      rpid_ff <= nxt_rpid; buf_ff <= nxt_buf; crc_ff <= nxt_crc; idx_ff <= nxt_idx;
      wait_ff <= nxt_wait; txd_ff <= nxt_txd; txv_ff <= nxt_txv; txl_ff <= nxt_txl; hold_ff <= nxt_hold;
      ka_ff <= nxt_ka; slot_ff <= nxt_slot; ka_cnt_ff <= nxt_ka_cnt;
    end
  end

  // apb answer: ready one cycle into the access phase, read data captured in setup
  always_comb begin
    nxt_rdy    = psel & penable & !rdy_ff;
    nxt_serr   = psel & penable & !rdy_ff & !hit;
    nxt_prdata = prdata_ff;
    if (rd) begin
      nxt_prdata = 32'h0;
      if (paddr == usb_dbg_pkg::OFS_CTRL) begin
        nxt_prdata[usb_dbg_pkg::CTRL_LEN_LSB +: 4] = len_ff;
        nxt_prdata[usb_dbg_pkg::CTRL_DIR]          = dir_ff;
        nxt_prdata[usb_dbg_pkg::CTRL_GO]           = go_ff;
        nxt_prdata[usb_dbg_pkg::CTRL_ERR]          = err_ff;
        nxt_prdata[usb_dbg_pkg::CTRL_EXC_LSB +: 3] = exc_ff;
        nxt_prdata[usb_dbg_pkg::CTRL_IN_USE]       = (st_ff != usb_dbg_pkg::ST_IDLE);
        nxt_prdata[usb_dbg_pkg::CTRL_DONE]         = done_ff;
        nxt_prdata[usb_dbg_pkg::CTRL_ENABLE]       = enable_ff;
        nxt_prdata[usb_dbg_pkg::CTRL_OWNER]        = owner_ff;
      end else if (paddr == usb_dbg_pkg::OFS_PIDS) begin
        nxt_prdata[23:0] = {rpid_ff, spid_ff, tpid_ff};
      end else if (paddr == usb_dbg_pkg::OFS_DATA0) begin
        nxt_prdata = buf_ff[31:0];
      end else if (paddr == usb_dbg_pkg::OFS_DATA1) begin
        nxt_prdata = buf_ff[63:32];
      end else if (paddr == usb_dbg_pkg::OFS_ADDR) begin
        nxt_prdata[14:0] = {dev_ff, 4'h0, ep_ff};
      end else if (paddr == usb_dbg_pkg::OFS_STAT) begin
        nxt_prdata[3:0] = {hold_ff, may_run & run_stop, mode1, may_run};
      end
    end
    // port-level indications
    nxt_act = may_run;                                          // see [R6] [R18]
    nxt_blk = cfg_on & !p_en;                                   // see [R17]
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdy_ff <= 1'b0; serr_ff <= 1'b0; prdata_ff <= 32'h0; act_ff <= 1'b0; blk_ff <= 1'b0;
    end else begin
      rdy_ff <= nxt_rdy; serr_ff <= nxt_serr; prdata_ff <= nxt_prdata; act_ff <= nxt_act; blk_ff <= nxt_blk;
    end
  end

  // outputs straight from flip-flops
  assign prdata         = prdata_ff;
  assign pready         = rdy_ff;
  assign pslverr        = serr_ff;
  assign tx_valid       = txv_ff;
  assign tx_data        = txd_ff;
  assign tx_last        = txl_ff;
  assign keepalive_sync = ka_ff;
  assign debug_active   = act_ff;
  assign normal_block   = blk_ff;

  // checks
  property p_one_slot;
    @(posedge core_clk) disable iff (!nrst) start |-> slot_hit && !$past(start);
  endproperty
  a_one_slot: assert property (p_one_slot) else $error("start outside slot"); // see [R5]
  property p_ka_stopped;
    @(posedge core_clk) disable iff (!nrst) ka_ff |-> !$past(run_stop) && $past(st_ff) == usb_dbg_pkg::ST_IDLE;
  endproperty
  a_ka_stopped: assert property (p_ka_stopped) else $error("keepalive while running"); // see [R10]
  property p_ka_due;
    @(posedge core_clk) disable iff (!nrst)
      (mode1 && !start && st_ff == usb_dbg_pkg::ST_IDLE && ka_cnt_ff == KA_CYCLES - 1) |=> ka_ff && !txv_ff;
  endproperty
  a_ka_due: assert property (p_ka_due) else $error("keepalive missed"); // see [R8]
  property p_idle_off;
    @(posedge core_clk) disable iff (!nrst)
      (!cfg_on && st_ff == usb_dbg_pkg::ST_IDLE) |=> st_ff == usb_dbg_pkg::ST_IDLE && !ka_ff;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("activity while off"); // see [R15]
  property p_no_hs;
    @(posedge core_clk) disable iff (!nrst)
      (st_ff == usb_dbg_pkg::ST_WAIT && !rx_valid && !p_rst && wait_ff == 8'(usb_dbg_pkg::RESP_CYC - 1))
      |=> done_ff && err_ff && exc_ff == usb_dbg_pkg::EXC_NO_RESP && st_ff == usb_dbg_pkg::ST_IDLE;
  endproperty
  a_no_hs: assert property (p_no_hs) else $error("timeout status wrong"); // see [R26]
  property p_hs;
    @(posedge core_clk) disable iff (!nrst) (st_ff == usb_dbg_pkg::ST_WAIT && rx_valid)
      |=> done_ff && !err_ff && rpid_ff == $past(rx_data);
  endproperty
  a_hs: assert property (p_hs) else $error("handshake status wrong"); // see [R25]
  property p_hold;
    @(posedge core_clk) disable iff (!nrst) (hold_ff || p_susp || p_rst || !power_d0) |-> !start;
  endproperty
  a_hold: assert property (p_hold) else $error("start during hold off"); // see [R12]
  property p_token;
    @(posedge core_clk) disable iff (!nrst) start |=> txv_ff && txd_ff == tpid_ff && !txl_ff && !go_ff;
  endproperty
  a_token: assert property (p_token) else $error("token pid not first"); // see [R23]
  property p_finish;
    @(posedge core_clk) disable iff (!nrst)
      $rose(st_ff == usb_dbg_pkg::ST_WAIT) |-> ##[1:64] (done_ff && st_ff == usb_dbg_pkg::ST_IDLE);
  endproperty
  a_finish: assert property (p_finish) else $error("transaction never finished"); // see [R4]
  c_ka:   cover property (@(posedge core_clk) disable iff (!nrst) ka_ff);
  c_ok:   cover property (@(posedge core_clk) disable iff (!nrst) $rose(done_ff) && !err_ff);
  c_err:  cover property (@(posedge core_clk) disable iff (!nrst) $rose(done_ff) && err_ff);
  c_hold: cover property (@(posedge core_clk) disable iff (!nrst) $fell(hold_ff) && $past(sof_sent));

endmodule : usb_debug_port_controller
`default_nettype wire

// [usb_console_model.sv]
// console model on the phy byte side: takes tx bytes, answers with a handshake
// assumes the byte interface of the debug port controller on core_clk
`default_nettype none
module usb_console_model (
  input  wire logic       core_clk,   // core clock
  input  wire logic       tx_valid,   // byte offered
  input  wire logic [7:0] tx_data,    // offered byte
  input  wire logic       tx_last,    // last byte of packet
  input  wire logic       slow,       // stall every other beat
  input  wire logic       mute,       // withhold the handshake
  output logic            tx_ready,   // byte taken
  output logic            rx_valid,   // handshake pulse
  output logic      [7:0] rx_data,    // handshake pid, toggles when idle
  output logic      [7:0] first_byte, // first byte of the latest token
  output logic      [7:0] data_cnt    // bytes in the latest data packet
);
  timeunit 1ns;
  timeprecision 1ns;
  int   pkt = 0;
  int   gap = 0;
  int   cnt = 0;
  logic sop = 1'b1;
  // high-speed console straight on the port: handshake 3 cycles after data
  always @(posedge core_clk) begin
    rx_data  <= (gap == 1 && !mute) ? 8'hd2 : ~rx_data;
    rx_valid <= gap == 1 && !mute;
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (gap > 0) gap <= gap - 1;
    if (tx_valid && tx_ready) begin
      if (sop && pkt == 0) first_byte <= tx_data;
      sop <= tx_last;
      cnt <= tx_last ? 0 : cnt + 1;
      if (tx_last && pkt == 1) data_cnt <= 8'(cnt + 1);
      if (tx_last) pkt <= (pkt == 1) ? 0 : 1;
      if (tx_last && pkt == 1) gap <= 3;
    end
  end
  initial begin
    tx_ready = 1'b0;
    rx_data = 8'h00;
    first_byte = 8'h00;
    data_cnt = 8'h00;
    rx_valid = 1'b0;
  end
endmodule : usb_console_model
`default_nettype wire

// [usb_debug_port_controller_bench.sv]
// testbench for the usb debug port controller: apb tasks and scenarios
// assumes the console model on the byte side and a 25 MHz core clock
`default_nettype none
module usb_debug_port_controller_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, run_stop = 0, power_d0 = 1, sof_sent = 0;
  logic slow = 0, mute = 0, pready, pslverr, tx_ready, rx_valid, tx_valid, tx_last, keepalive_sync;
  logic debug_active, normal_block, e;
  logic [7:0] paddr = 8'h00, rx_data, tx_data, first_byte, data_cnt;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0] port_enable = 4'h0, port_suspend = 4'h0, port_reset = 4'h0;
  int err_total = 0, n_compared = 0;
  usb_debug_port_controller #(.KA_CYCLES(50)) DUT (.core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .port_enable, .port_suspend, .port_reset, .run_stop, .power_d0, .sof_sent,
    .tx_ready, .rx_valid, .rx_data, .tx_valid, .tx_data, .tx_last, .keepalive_sync, .debug_active, .normal_block);
  usb_console_model console (.core_clk, .tx_valid, .tx_data, .tx_last, .slow, .mute, .tx_ready, .rx_valid,
    .rx_data, .first_byte, .data_cnt);
  always #20 core_clk = ~core_clk;
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  // out transfer of two bytes; owner, enable, done clear, go, direction out
  task automatic run_out(input logic exp_err, input logic [2:0] exp_exc);
    int n;
    n = 0;
    apb(1, 8'h00, 32'h5001_0032);
    do begin apb(0, 8'h00, 0); n++; end while (q[16] !== 1'b1 && n < 2000);
    chk("done", q[16], 1);
    chk("poll in time", n <= 820, 1);
    chk("token pid", first_byte, 8'he1);
    chk("data bytes", data_cnt, 8'h05);
    chk("error", q[6], exp_err);
    chk("exception", q[9:7], exp_exc);
    apb(0, 8'h04, 0);
    if (!exp_err) chk("returned pid", q[23:16], 8'hd2);
  endtask : run_out
  // keepalive spacing and count over 300 cycles
  task automatic keep(input logic rs, input int exp_n);
    int k, g, m;
    k = 0; g = 0; m = 0;
    run_stop <= rs;
    repeat (2) @(posedge core_clk);
    repeat (300) begin
      @(posedge core_clk);
      g = keepalive_sync ? 0 : g + 1;
      k += keepalive_sync;
      if (g > m) m = g;
    end
    if (rs) chk("keepalives", k, exp_n);
    else chk("keepalive gap ok", m <= 50 && k >= exp_n, 1);
  endtask : keep
  task automatic st(input logic [3:0] pe, ps, pr, input logic rs, d0, act, blk);
    port_enable <= pe; port_suspend <= ps; port_reset <= pr; run_stop <= rs; power_d0 <= d0;
    repeat (3) @(posedge core_clk);
    chk("active", debug_active, act);
    chk("normal block", normal_block, blk);
  endtask : st
  task automatic sof();
    sof_sent <= 1'b1;
    @(posedge core_clk) sof_sent <= 1'b0;
  endtask : sof
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    #2000000;
    err_total++;
    finish_test();
  end
  // reset, then the scenarios; the port is never left enabled, stopped and awake
  initial begin
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    apb(0, 8'h18, 0);
    chk("unmapped", e, 1);
    apb(1, 8'h04, 32'h0000_c3e1);
    apb(1, 8'h08, 32'h0000_a55a);
    apb(1, 8'h10, 32'h0000_0502);
    run_out(0, 3'h0);
    mute <= 1'b1; slow <= 1'b1;
    run_out(1, 3'h1);
    mute <= 1'b0;
    keep(0, 5);
    keep(1, 0);
    st(4'h0, 4'h0, 4'h0, 1, 1, 1, 1);
    st(4'h2, 4'h0, 4'h0, 1, 1, 1, 0);
    apb(0, 8'h00, 0);
    chk("enable kept", q[28], 1);
    st(4'h2, 4'h2, 4'h0, 1, 1, 0, 0);
    st(4'h2, 4'h0, 4'h0, 1, 1, 0, 0);
    sof();
    st(4'h2, 4'h0, 4'h0, 1, 1, 1, 0);
    st(4'h2, 4'h0, 4'h2, 1, 1, 0, 0);
    st(4'h2, 4'h0, 4'h0, 1, 1, 0, 0);
    sof();
    st(4'h2, 4'h0, 4'h0, 1, 1, 1, 0);
    st(4'h2, 4'hd, 4'hd, 1, 1, 1, 0);
    st(4'h0, 4'h0, 4'h0, 1, 0, 0, 1);
    apb(1, 8'h00, 32'h4000_0000);
    st(4'h0, 4'h0, 4'h0, 0, 1, 0, 0);
    finish_test();
  end
endmodule : usb_debug_port_controller_bench
`default_nettype wire
